// >>> port_phy_status_diag_defines.svh
// port_phy_status_diag_defines.svh: addresses, field positions and reset values.
// assumes: included by bare name into the package and the register bank.
`ifndef PORT_PHY_STATUS_DIAG_DEFINES_SVH
`define PORT_PHY_STATUS_DIAG_DEFINES_SVH

// ----------------------------------------------------------------------------
// bank bases (byte addresses) and register indices (byte address = base + 4*index)
// ----------------------------------------------------------------------------
`define ADDR_W 12
`define PORT1_STATUS_BANK_BASE 12'h000
`define PORT2_CTRL_BANK_BASE 12'h040
`define PORT2_PHY_BANK_BASE 12'h080
`define PORT1_LINK_STATUS_IDX 4'h4
`define PORT2_CONTROL_ONE_IDX 4'h0
`define PORT2_CONTROL_TWO_IDX 4'h2
`define PORT2_VLAN_ID_CONTROL_IDX 4'h4
`define PORT2_CONTROL_THREE_IDX 4'h6
`define PORT2_INGRESS_RATE_IDX 4'h8
`define PORT2_EGRESS_RATE_IDX 4'ha
`define PORT2_PHY_SPECIAL_DIAG_IDX 4'h0

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define P1_CROSSOVER_SEL_BIT 15
`define P1_POLARITY_BIT 13
`define P1_RX_PAUSE_BIT 12
`define P1_TX_PAUSE_BIT 11
`define P1_SPEED_BIT 10
`define P1_DUPLEX_BIT 9
`define P1_MDIX_BIT 7
`define P1_NEG_DONE_BIT 6
`define P1_LINK_GOOD_BIT 5
`define P1_PARTNER_MSB 4
`define P2_SHORT_NEAR_BIT 15
`define P2_RESULT_MSB 14
`define P2_RESULT_LSB 13
`define P2_DIAG_START_BIT 12
`define P2_LINK_PASS_BIT 11
`define P2_PWRSAVE_DIS_BIT 10
`define P2_NEAR_LOOP_BIT 9
`define P2_FAULT_MSB 8

// ----------------------------------------------------------------------------
// reset values and bus answers
// ----------------------------------------------------------------------------
`define RST_CROSSOVER_SEL 1'h1
`define RST_PWRSAVE_DIS 1'h1
`define RST_PORT2_CTRL 16'h0000
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

`endif

// >>> port_phy_status_diag_pkg.sv
// port_phy_status_diag_pkg.sv: types shared by the register bank and its users.
// assumes: the defines header sits in the include path.
`include "port_phy_status_diag_defines.svh"

package port_phy_status_diag_pkg;

	// live port 1 status from the phy and mac, same clock
	typedef struct packed {
		logic polarity_reversed;
		logic rx_pause_active;
		logic tx_pause_active;
		logic speed_100;
		logic duplex_full;
		logic mdi_mode;
		logic negotiation_complete;
		logic link_good;
		logic [4:0] partner_ability;
	} phy_status_t;

	// cable test outcome, valid with i_diag_done
	typedef struct packed {
		logic cable_short_near;
		logic [1:0] outcome;
		logic [8:0] fault_count;
	} diag_result_t;

	typedef enum logic [1:0] {
		KIND_NONE = 2'b00,
		KIND_P1_STATUS = 2'b01,
		KIND_P2_CTRL = 2'b10,
		KIND_P2_PHY = 2'b11
	} reg_kind_t;

	typedef struct packed {
		reg_kind_t kind;
		logic [2:0] slot;
	} reg_dec_t;

	typedef enum logic [0:0] {
		DIAG_IDLE = 1'b0,
		DIAG_RUN = 1'b1
	} diag_state_t;

	// whole state of the register bank
	typedef struct packed {
		logic aw_have;
		logic [`ADDR_W-1:0] aw_addr;
		logic w_have;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic crossover_flavour_sel;
		logic [5:0][15:0] port2_ctrl;
		logic link_pass_override;
		logic pwrsave_disable;
		logic near_loopback;
		diag_state_t diag_state;
		logic diag_start_pulse;
		diag_result_t diag_result;
	} bank_state_t;

endpackage

// >>> port_phy_status_diag_regs.sv
// port_phy_status_diag_regs.sv: port 1 status and port 2 control/phy special registers.
// assumes: axi4-lite master on i_clock; phy status and cable test logic on the same clock.
//
// Function
// - read-write bit 15 picks crossover algorithm
// - bit 13 reports receive polarity reversed
// - bit 12 shows receive pause active
// - bit 11 shows transmit pause active
// - bit 10 reports 100 or 10 speed
// - bit 9 reports full or half duplex
// - bits 4..0 show partner abilities
// - port 2 control registers at 0x00..0x0a
// - bits 14..13 hold cable test outcome
// - bit 15 flags short under 10 metres
// - writing 1 starts test, self clears
// - bit 11 forces link pass state
// - bit 10 disables power saving, default 1
// - bit 9 loops port 2 line back
// - bits 8..0 hold fault distance count
`include "port_phy_status_diag_defines.svh"

module port_phy_status_diag_regs (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic [`ADDR_W-1:0] i_s_axi_awaddr,
	input wire logic [2:0] i_s_axi_awprot,
	input wire logic i_s_axi_awvalid,
	output logic o_s_axi_awready,
	input wire logic [31:0] i_s_axi_wdata,
	input wire logic [3:0] i_s_axi_wstrb,
	input wire logic i_s_axi_wvalid,
	output logic o_s_axi_wready,
	output logic [1:0] o_s_axi_bresp,
	output logic o_s_axi_bvalid,
	input wire logic i_s_axi_bready,
	input wire logic [`ADDR_W-1:0] i_s_axi_araddr,
	input wire logic [2:0] i_s_axi_arprot,
	input wire logic i_s_axi_arvalid,
	output logic o_s_axi_arready,
	output logic [31:0] o_s_axi_rdata,
	output logic [1:0] o_s_axi_rresp,
	output logic o_s_axi_rvalid,
	input wire logic i_s_axi_rready,
	input wire port_phy_status_diag_pkg::phy_status_t i_phy_status,
	input wire logic i_diag_done,
	input wire port_phy_status_diag_pkg::diag_result_t i_diag_result,
	output logic o_crossover_flavour_sel,
	output logic [5:0][15:0] o_port2_ctrl,
	output logic o_diag_start,
	output logic o_link_pass_override,
	output logic o_pwrsave_disable,
	output logic o_near_loopback
);

	// ------------------------------------------------------------------------
	// state and decode
	// ------------------------------------------------------------------------
	port_phy_status_diag_pkg::bank_state_t st_ff;
	port_phy_status_diag_pkg::bank_state_t nxt_st;
	port_phy_status_diag_pkg::reg_dec_t wr_dec;
	port_phy_status_diag_pkg::reg_dec_t rd_dec;
	logic wr_fire;
	logic rd_fire;

	// one decoder for both channels so reads and writes never disagree on the map
	function automatic port_phy_status_diag_pkg::reg_dec_t decode(
		input logic [`ADDR_W-1:0] addr
	);
		port_phy_status_diag_pkg::reg_dec_t d;
		logic [`ADDR_W-1:0] base;
		logic [3:0] word;
		d.kind = port_phy_status_diag_pkg::KIND_NONE;
		d.slot = 3'h0;
		base = {addr[`ADDR_W-1:6], 6'h00};
		word = addr[5:2];
		if (base == `PORT1_STATUS_BANK_BASE && word == `PORT1_LINK_STATUS_IDX) begin
			d.kind = port_phy_status_diag_pkg::KIND_P1_STATUS;
		end else if (base == `PORT2_CTRL_BANK_BASE && !word[0] &&
				word <= `PORT2_EGRESS_RATE_IDX) begin
			d.kind = port_phy_status_diag_pkg::KIND_P2_CTRL;
			d.slot = word[3:1];
		end else if (base == `PORT2_PHY_BANK_BASE && word == `PORT2_PHY_SPECIAL_DIAG_IDX) begin
			d.kind = port_phy_status_diag_pkg::KIND_P2_PHY;
		end
		return d;
	endfunction

	// merges 16-bit write data under the two low byte strobes
	function automatic logic [15:0] merge16(
		input logic [15:0] old,
		input logic [31:0] data,
		input logic [3:0] strb
	);
		logic [15:0] r;
		r = old;
		if (strb[0]) begin
			r[7:0] = data[7:0];
		end
		if (strb[1]) begin
			r[15:8] = data[15:8];
		end
		return r;
	endfunction

	// ------------------------------------------------------------------------
	// read image
	// ------------------------------------------------------------------------
	function automatic logic [15:0] status_word(
		input port_phy_status_diag_pkg::bank_state_t s,
		input port_phy_status_diag_pkg::phy_status_t p
	);
		logic [15:0] v;
		v = 16'h0000; // reserved bits 14 and 8 stay zero
		v[`P1_CROSSOVER_SEL_BIT] = s.crossover_flavour_sel;
		v[`P1_POLARITY_BIT] = p.polarity_reversed;
		v[`P1_RX_PAUSE_BIT] = p.rx_pause_active;
		v[`P1_TX_PAUSE_BIT] = p.tx_pause_active;
		v[`P1_SPEED_BIT] = p.speed_100;
		v[`P1_DUPLEX_BIT] = p.duplex_full;
		v[`P1_MDIX_BIT] = p.mdi_mode;
		v[`P1_NEG_DONE_BIT] = p.negotiation_complete;
		v[`P1_LINK_GOOD_BIT] = p.link_good;
		v[`P1_PARTNER_MSB:0] = p.partner_ability;
		return v;
	endfunction

	function automatic logic [15:0] phy_word(
		input port_phy_status_diag_pkg::bank_state_t s
	);
		logic [15:0] v;
		v = 16'h0000;
		v[`P2_SHORT_NEAR_BIT] = s.diag_result.cable_short_near;
		v[`P2_RESULT_MSB:`P2_RESULT_LSB] = s.diag_result.outcome;
		v[`P2_DIAG_START_BIT] = (s.diag_state == port_phy_status_diag_pkg::DIAG_RUN);
		v[`P2_LINK_PASS_BIT] = s.link_pass_override;
		v[`P2_PWRSAVE_DIS_BIT] = s.pwrsave_disable;
		v[`P2_NEAR_LOOP_BIT] = s.near_loopback;
		v[`P2_FAULT_MSB:0] = s.diag_result.fault_count;
		return v;
	endfunction

	// ------------------------------------------------------------------------
	// bus handshakes
	// ------------------------------------------------------------------------
	// address and data channels close while a response is pending: one write at a time
	assign o_s_axi_awready = !st_ff.aw_have && !st_ff.bvalid;
	assign o_s_axi_wready = !st_ff.w_have && !st_ff.bvalid;
	assign o_s_axi_arready = !st_ff.rvalid;
	assign wr_fire = st_ff.aw_have && st_ff.w_have && !st_ff.bvalid;
	assign rd_fire = i_s_axi_arvalid && o_s_axi_arready;
	assign wr_dec = decode(st_ff.aw_addr);
	assign rd_dec = decode(i_s_axi_araddr);

	// ------------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------------
	always_comb begin
		nxt_st = st_ff;
		nxt_st.diag_start_pulse = 1'b0;
		// write address and data captured independently, in either order
		if (i_s_axi_awvalid && o_s_axi_awready) begin
			nxt_st.aw_have = 1'b1;
			nxt_st.aw_addr = i_s_axi_awaddr;
		end
		if (i_s_axi_wvalid && o_s_axi_wready) begin
			nxt_st.w_have = 1'b1;
			nxt_st.w_data = i_s_axi_wdata;
			nxt_st.w_strb = i_s_axi_wstrb;
		end
		if (st_ff.bvalid && i_s_axi_bready) begin
			nxt_st.bvalid = 1'b0;
		end
		// cable test: completion latches the outcome and clears the start bit
		case (st_ff.diag_state)
			port_phy_status_diag_pkg::DIAG_IDLE: begin
				nxt_st.diag_state = port_phy_status_diag_pkg::DIAG_IDLE;
			end
			port_phy_status_diag_pkg::DIAG_RUN: begin
				if (i_diag_done) begin
					nxt_st.diag_state = port_phy_status_diag_pkg::DIAG_IDLE;
					nxt_st.diag_result = i_diag_result;
				end
			end
			default: begin
				nxt_st.diag_state = port_phy_status_diag_pkg::DIAG_IDLE;
			end
		endcase
		// register write; comes after completion so a new start wins over the clear
		if (wr_fire) begin
			nxt_st.aw_have = 1'b0;
			nxt_st.w_have = 1'b0;
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp = `RESP_OKAY;
			if (wr_dec.kind == port_phy_status_diag_pkg::KIND_P1_STATUS) begin
				// only the crossover select is writable, status bits ignore writes
				if (st_ff.w_strb[1]) begin
					nxt_st.crossover_flavour_sel = st_ff.w_data[`P1_CROSSOVER_SEL_BIT];
				end
			end else if (wr_dec.kind == port_phy_status_diag_pkg::KIND_P2_CTRL) begin
				nxt_st.port2_ctrl[wr_dec.slot] = merge16(st_ff.port2_ctrl[wr_dec.slot],
					st_ff.w_data, st_ff.w_strb);
			end else if (wr_dec.kind == port_phy_status_diag_pkg::KIND_P2_PHY) begin
				if (st_ff.w_strb[1]) begin
					nxt_st.link_pass_override = st_ff.w_data[`P2_LINK_PASS_BIT];
					nxt_st.pwrsave_disable = st_ff.w_data[`P2_PWRSAVE_DIS_BIT];
					nxt_st.near_loopback = st_ff.w_data[`P2_NEAR_LOOP_BIT];
					// writing 0 to the start bit cannot abort a running test
					if (st_ff.w_data[`P2_DIAG_START_BIT]) begin
						nxt_st.diag_state = port_phy_status_diag_pkg::DIAG_RUN;
						nxt_st.diag_start_pulse = 1'b1;
					end
				end
			end else begin
				nxt_st.bresp = `RESP_DECERR;
			end
		end
		// read channel; status is sampled at the address handshake
		if (st_ff.rvalid && i_s_axi_rready) begin
			nxt_st.rvalid = 1'b0;
		end
		if (rd_fire) begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rresp = `RESP_OKAY;
			nxt_st.rdata = 32'h0000_0000;
			if (rd_dec.kind == port_phy_status_diag_pkg::KIND_P1_STATUS) begin
				nxt_st.rdata = {16'h0000, status_word(st_ff, i_phy_status)};
			end else if (rd_dec.kind == port_phy_status_diag_pkg::KIND_P2_CTRL) begin
				nxt_st.rdata = {16'h0000, st_ff.port2_ctrl[rd_dec.slot]};
			end else if (rd_dec.kind == port_phy_status_diag_pkg::KIND_P2_PHY) begin
				nxt_st.rdata = {16'h0000, phy_word(st_ff)};
			end else begin
				nxt_st.rresp = `RESP_DECERR;
			end
		end
	end

	// ------------------------------------------------------------------------
	// state register
	// ------------------------------------------------------------------------
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			st_ff <= '0;
			st_ff.crossover_flavour_sel <= `RST_CROSSOVER_SEL;
			st_ff.pwrsave_disable <= `RST_PWRSAVE_DIS;
			st_ff.port2_ctrl <= {6{`RST_PORT2_CTRL}};
			st_ff.diag_state <= port_phy_status_diag_pkg::DIAG_IDLE;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// outputs straight from flip-flops
	assign o_s_axi_bvalid = st_ff.bvalid;
	assign o_s_axi_bresp = st_ff.bresp;
	assign o_s_axi_rvalid = st_ff.rvalid;
	assign o_s_axi_rdata = st_ff.rdata;
	assign o_s_axi_rresp = st_ff.rresp;
	assign o_crossover_flavour_sel = st_ff.crossover_flavour_sel;
	assign o_port2_ctrl = st_ff.port2_ctrl;
	assign o_diag_start = st_ff.diag_start_pulse;
	assign o_link_pass_override = st_ff.link_pass_override;
	assign o_pwrsave_disable = st_ff.pwrsave_disable;
	assign o_near_loopback = st_ff.near_loopback;

	// ------------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------------
	// helpers: which register a write or read hits
	logic wr_p1;
	logic wr_p2c;
	logic wr_phy_hi;
	logic rd_p1;
	logic rd_phy;
	assign wr_p1 = wr_fire && wr_dec.kind == port_phy_status_diag_pkg::KIND_P1_STATUS;
	assign wr_p2c = wr_fire && wr_dec.kind == port_phy_status_diag_pkg::KIND_P2_CTRL;
	assign wr_phy_hi = wr_fire && wr_dec.kind == port_phy_status_diag_pkg::KIND_P2_PHY &&
		st_ff.w_strb[1];
	assign rd_p1 = rd_fire && rd_dec.kind == port_phy_status_diag_pkg::KIND_P1_STATUS;
	assign rd_phy = rd_fire && rd_dec.kind == port_phy_status_diag_pkg::KIND_P2_PHY;

	property p_crossover_write;
		@(posedge i_clock) disable iff (i_rst)
		(wr_p1 && st_ff.w_strb[1]) |=>
			o_crossover_flavour_sel == $past(st_ff.w_data[15]) && o_s_axi_bvalid;
	endproperty
	a_crossover_write: assert property (p_crossover_write)
		else $error("crossover select not taken from write");

	property p_polarity_read;
		@(posedge i_clock) disable iff (i_rst)
		rd_p1 |=> o_s_axi_rvalid && o_s_axi_rdata[13] == $past(i_phy_status.polarity_reversed);
	endproperty
	a_polarity_read: assert property (p_polarity_read)
		else $error("polarity bit wrong on read");

	property p_rx_pause_read;
		@(posedge i_clock) disable iff (i_rst)
		rd_p1 |=> o_s_axi_rdata[12] == $past(i_phy_status.rx_pause_active);
	endproperty
	a_rx_pause_read: assert property (p_rx_pause_read)
		else $error("receive pause bit wrong");

	property p_tx_pause_read;
		@(posedge i_clock) disable iff (i_rst)
		rd_p1 |=> o_s_axi_rdata[11] == $past(i_phy_status.tx_pause_active);
	endproperty
	a_tx_pause_read: assert property (p_tx_pause_read)
		else $error("transmit pause bit wrong");

	property p_speed_read;
		@(posedge i_clock) disable iff (i_rst)
		rd_p1 |=> o_s_axi_rdata[10] == $past(i_phy_status.speed_100);
	endproperty
	a_speed_read: assert property (p_speed_read)
		else $error("speed bit wrong");

	property p_duplex_read;
		@(posedge i_clock) disable iff (i_rst)
		rd_p1 |=> o_s_axi_rdata[9] == $past(i_phy_status.duplex_full);
	endproperty
	a_duplex_read: assert property (p_duplex_read)
		else $error("duplex bit wrong");

	property p_partner_read;
		@(posedge i_clock) disable iff (i_rst)
		rd_p1 |=> o_s_axi_rdata[4:0] == $past(i_phy_status.partner_ability);
	endproperty
	a_partner_read: assert property (p_partner_read)
		else $error("partner ability bits wrong");

	property p_port2_ctrl_write;
		@(posedge i_clock) disable iff (i_rst)
		(wr_p2c && st_ff.w_strb[1:0] == 2'b11) |=>
			o_port2_ctrl[$past(wr_dec.slot)] == $past(st_ff.w_data[15:0]);
	endproperty
	a_port2_ctrl_write: assert property (p_port2_ctrl_write)
		else $error("port 2 control word not stored");

	property p_outcome_latch;
		@(posedge i_clock) disable iff (i_rst)
		(st_ff.diag_state == port_phy_status_diag_pkg::DIAG_RUN && i_diag_done) |=>
			st_ff.diag_result.outcome == $past(i_diag_result.outcome);
	endproperty
	a_outcome_latch: assert property (p_outcome_latch)
		else $error("cable test outcome not latched");

	property p_short_read;
		@(posedge i_clock) disable iff (i_rst)
		rd_phy |=> o_s_axi_rdata[15] == $past(st_ff.diag_result.cable_short_near) &&
			o_s_axi_rdata[14:13] == $past(st_ff.diag_result.outcome);
	endproperty
	a_short_read: assert property (p_short_read)
		else $error("short flag or outcome wrong on read");

	property p_start_clears;
		@(posedge i_clock) disable iff (i_rst)
		(wr_phy_hi && st_ff.w_data[12]) |=>
			o_diag_start ##1 !o_diag_start ##0
			(st_ff.diag_state == port_phy_status_diag_pkg::DIAG_RUN || $past(i_diag_done));
	endproperty
	a_start_clears: assert property (p_start_clears)
		else $error("start bit did not launch a single test pulse");

	property p_done_idles;
		@(posedge i_clock) disable iff (i_rst)
		(st_ff.diag_state == port_phy_status_diag_pkg::DIAG_RUN && i_diag_done && !wr_phy_hi) |=>
			st_ff.diag_state == port_phy_status_diag_pkg::DIAG_IDLE;
	endproperty
	a_done_idles: assert property (p_done_idles)
		else $error("start bit not self cleared on completion");

	property p_link_pass;
		@(posedge i_clock) disable iff (i_rst)
		wr_phy_hi |=> o_link_pass_override == $past(st_ff.w_data[11]);
	endproperty
	a_link_pass: assert property (p_link_pass)
		else $error("link pass override not following write");

	property p_pwrsave;
		@(posedge i_clock) disable iff (i_rst)
		wr_phy_hi |=> o_pwrsave_disable == $past(st_ff.w_data[10]);
	endproperty
	a_pwrsave: assert property (p_pwrsave)
		else $error("power save disable not following write");

	property p_loopback;
		@(posedge i_clock) disable iff (i_rst)
		wr_phy_hi |=> o_near_loopback == $past(st_ff.w_data[9]);
	endproperty
	a_loopback: assert property (p_loopback)
		else $error("near loopback not following write");

	property p_fault_count;
		@(posedge i_clock) disable iff (i_rst)
		(st_ff.diag_state == port_phy_status_diag_pkg::DIAG_RUN && i_diag_done) |=>
			st_ff.diag_result.fault_count == $past(i_diag_result.fault_count);
	endproperty
	a_fault_count: assert property (p_fault_count)
		else $error("fault count not latched");

	property p_negotiation_link;
		@(posedge i_clock) disable iff (i_rst)
		rd_p1 |=> o_s_axi_rdata[6] == $past(i_phy_status.negotiation_complete) &&
			o_s_axi_rdata[5] == $past(i_phy_status.link_good);
	endproperty
	a_negotiation_link: assert property (p_negotiation_link)
		else $error("negotiation or link bit wrong");

	property p_reserved_zero;
		@(posedge i_clock) disable iff (i_rst)
		rd_p1 |=> o_s_axi_rdata[14] == 1'b0 && o_s_axi_rdata[8] == 1'b0 &&
			o_s_axi_rdata[31:16] == 16'h0000;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("reserved status bits not zero");

endmodule

// >>> port_phy_status_diag_regs_bench.sv
// port_phy_status_diag_regs_bench.sv: self-checking bench for the register bank.
// assumes: package and defines compiled first; one 100 MHz clock, axi4-lite host only.
module port_phy_status_diag_regs_bench;
	timeunit 1ns;
	timeprecision 100ps;

	// ------------
	// stimulus and observed signals
	// ------------
	logic i_clock = 1'h0;
	logic i_rst = 1'h1;
	logic [11:0] awaddr = 12'h000;
	logic [11:0] araddr = 12'h000;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic diag_done = 1'h0;
	logic awready, wready, bvalid, arready, rvalid, crossover, diag_start;
	logic link_pass, pwrsave_dis, near_loop;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [5:0][15:0] port2_ctrl;
	port_phy_status_diag_pkg::phy_status_t phy_status = '0;
	port_phy_status_diag_pkg::diag_result_t diag_result = '0;
	port_phy_status_diag_pkg::diag_result_t res, nres;
	int fails = 0;
	int total_checks = 0;
	int starts = 0;

	// free-running clock; start pulses counted every cycle since they last one cycle
	always #5 i_clock = ~i_clock;
	always @(posedge i_clock) if (diag_start === 1'h1) starts++;

	port_phy_status_diag_regs i_dut (
		.i_clock(i_clock), .i_rst(i_rst),
		.i_s_axi_awaddr(awaddr), .i_s_axi_awprot(3'h0), .i_s_axi_awvalid(awvalid),
		.o_s_axi_awready(awready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb),
		.i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .o_s_axi_bresp(bresp),
		.o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready), .i_s_axi_araddr(araddr),
		.i_s_axi_arprot(3'h0), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
		.o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
		.i_s_axi_rready(rready), .i_phy_status(phy_status), .i_diag_done(diag_done),
		.i_diag_result(diag_result), .o_crossover_flavour_sel(crossover),
		.o_port2_ctrl(port2_ctrl), .o_diag_start(diag_start),
		.o_link_pass_override(link_pass), .o_pwrsave_disable(pwrsave_dis),
		.o_near_loopback(near_loop)
	);

	// ------------
	// bus tasks and comparison
	// ------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// ready is sampled at the falling edge: inputs only move at rising edges
	// no cycle limit of its own: only the watchdog ends a wait for the slave
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er);
		logic aw_done, w_done;
		aw_done = 1'h0;
		w_done = 1'h0;
		@(posedge i_clock);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(negedge i_clock);
			if (awvalid && awready) aw_done = 1'h1;
			if (wvalid && wready) w_done = 1'h1;
			@(posedge i_clock);
			if (aw_done) awvalid <= 1'h0;
			if (w_done) wvalid <= 1'h0;
		end while (!(aw_done && w_done));
		do begin
			@(negedge i_clock);
		end while (!bvalid);
		chk(32'({bvalid, bresp}), 32'({1'h1, er}));
		@(posedge i_clock);
		bready <= 1'h0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic ar_done;
		@(posedge i_clock);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(negedge i_clock);
			ar_done = arvalid && arready;
			@(posedge i_clock);
		end while (!ar_done);
		arvalid <= 1'h0;
		while (!rvalid) begin
			@(negedge i_clock);
		end
		chk(32'({rvalid, rresp}), 32'({1'h1, er}));
		chk(rdata, ed);
		@(posedge i_clock);
		rready <= 1'h0;
	endtask

	// special word with link pass and loopback on, power saving enabled
	function automatic logic [31:0] phy_word(input port_phy_status_diag_pkg::diag_result_t r,
		input logic busy);
		return {16'h0, r.cable_short_near, r.outcome, busy, 3'h5, r.fault_count};
	endfunction

	task automatic final_report();
		if (fails == 0 && total_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	// ------------
	// test sequence
	// ------------
	initial begin
		repeat (6) @(posedge i_clock);
		// handshakes open, responses idle, select and power-save disable at their defaults
		chk(32'({awready, wready, arready, bvalid, rvalid, crossover, pwrsave_dis, link_pass,
			near_loop, diag_start}), 32'h398);
		i_rst <= 1'h0;
		rd(12'h010, 32'h8000, 2'h0);
		rd(12'h080, 32'h0400, 2'h0);
		// each live status input lands at its own bit
		for (int k = 0; k < 13; k++) begin
			phy_status <= 13'(1 << k);
			rd(12'h010, 32'h8000 | (32'h1 << (k >= 8 ? k + 1 : k)), 2'h0);
		end
		phy_status <= '0;
		// read-only and reserved bits ignore writes; bit 15 needs the high strobe
		wr(12'h010, 32'h0000_ffff, 4'h3, 2'h0);
		rd(12'h010, 32'h8000, 2'h0);
		wr(12'h010, 32'h0, 4'h3, 2'h0);
		rd(12'h010, 32'h0, 2'h0);
		chk(32'(crossover), 32'h0);
		wr(12'h010, 32'h8000, 4'h1, 2'h0);
		rd(12'h010, 32'h0, 2'h0);
		// six control words, then an unmapped hole between them
		for (int k = 0; k < 6; k++) begin
			wr(12'h040 + 12'(8 * k), 32'(16'hffff >> k), 4'h3, 2'h0);
			rd(12'h040 + 12'(8 * k), 32'(16'hffff >> k), 2'h0);
			chk(32'(port2_ctrl[k]), 32'(16'hffff >> k));
		end
		wr(12'h044, 32'h1111, 4'h3, 2'h3);
		rd(12'h044, 32'h0, 2'h3);
		rd(12'h040, 32'hffff, 2'h0);
		// phy special controls; a low-strobe start write must not launch a test
		wr(12'h080, 32'h0a00, 4'h3, 2'h0);
		chk(32'({link_pass, pwrsave_dis, near_loop}), 32'h5);
		wr(12'h080, 32'h1a00, 4'h1, 2'h0);
		res = '0;
		rd(12'h080, phy_word(res, 1'h0), 2'h0);
		chk(32'(starts), 32'h0);
		// every outcome; old results stand while the test runs
		for (int k = 0; k < 4; k++) begin
			wr(12'h080, 32'h1a00, 4'h3, 2'h0);
			repeat (2) @(negedge i_clock);
			chk(32'(starts), 32'(k + 1));
			rd(12'h080, phy_word(res, 1'h1), 2'h0);
			nres = {(k == 2), 2'(k), 9'h1ff - 9'(k * 9'h0a5)};
			@(posedge i_clock);
			diag_done <= 1'h1;
			diag_result <= nres;
			@(posedge i_clock);
			diag_done <= 1'h0;
			res = nres;
			rd(12'h080, phy_word(res, 1'h0), 2'h0);
		end
		final_report();
	end

	// whole run is well under 2000 cycles
	initial begin
		#50000;
		fails++;
		final_report();
	end
endmodule
